// >>> ios_pkg.sv
// shared constants and carrier types for the indexer operand selectors
`default_nettype none

package ios_pkg;

  // widths, context count and register count
  localparam int DATA_W = 32;
  localparam int EA_W = 24;
  localparam int HALF_W = 16;
  localparam int RADDR_W = 8;
  localparam int EXT_W = 8;
  localparam int NUM_CTX = 8;
  localparam int NUM_REGS = 4;

  // instruction word fields, little-endian positions
  localparam int N_LSB = 0;
  localparam int R_LSB = 16;
  localparam int R_W = 8;
  localparam int T_LSB = 24;
  localparam int T_W = 4;
  localparam int SIGN_BIT = 31;
  // byte of the fourth context register used as base
  localparam int BASE_BYTE_LSB = 0;
  localparam int BASE_REG = 3;

  // index tags that mean no indexing
  localparam logic [3:0] T_NOIDX_A = 4'h0;
  localparam logic [3:0] T_NOIDX_B = 4'h8;

  // register map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LAST_EA_OFF = 8'h04;
  localparam logic [7:0] LAST_RA_OFF = 8'h08;
  localparam logic [7:0] COUNT_OFF = 8'h0C;
  // control fields, reset value and size field position of the last register address
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int RA_SIZE_LSB = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // operand size of the register access
  typedef enum logic [1:0] {
    IOS_SIZE_WORD,
    IOS_SIZE_HALF,
    IOS_SIZE_BYTE
  } ios_size_t;

  // decoded opcode and state controls
  typedef struct packed {
    logic pc_rel_imm;     // pc-relative branch or immediate operand
    logic stack_param;    // stack parameter modify step
    logic indirect_pass;  // indirect cell moving to instruction holder
    logic ea_incr;        // branch-and-save return or file store next
    logic stack_ptr;      // locate stack pointer parameter
    logic wce_test;       // word count exhaust test
    logic push_pull;      // push or pull stack instruction
    logic modify_counts;  // modify-stack word and space counts
    logic reg_is_cr;      // register spec names a communications reg
    ios_size_t size;      // operand size for the register access
  } ios_ctl_t;

  // main instruction holder view
  typedef struct packed {
    logic nil_swb;        // next instruction sits in stored word buffer
    logic [EA_W-1:0] ea;  // effective address
  } ios_main_t;

  // result for the context instruction holder
  typedef struct packed {
    logic [EA_W-1:0] eff_addr;
    logic [RADDR_W-1:0] reg_addr;
    ios_size_t size;
  } ios_out_t;

  // operand b source
  typedef enum logic [2:0] {
    IOS_B_NIR_N,
    IOS_B_SWB_N,
    IOS_B_EXT,
    IOS_B_SWB_WORD,
    IOS_B_MAIN_EA
  } ios_bsel_t;

endpackage : ios_pkg

`default_nettype wire

// >>> ios_adder24.sv
// three-input effective address adder with split halfword carry
`timescale 1ns/1ns
`default_nettype none

module ios_adder24 (
  // operands
  input wire logic [23:0] op_a,
  input wire logic [23:0] op_b,
  input wire logic [23:0] op_c,
  // carry controls
  input wire logic carry_in,
  input wire logic split_carry,
  // result
  output logic [23:0] sum
);

  logic [17:0] low_sum;  // lower halfword plus two carry bits
  logic [1:0] mid_carry; // carry into upper byte
  logic [7:0] high_sum;  // upper byte

  // lower halfword with forced carry
  assign low_sum = {2'b00, op_a[15:0]} + {2'b00, op_b[15:0]}
                 + {2'b00, op_c[15:0]} + {17'h0_0000, carry_in};
  assign mid_carry = split_carry ? 2'b00 : low_sum[17:16];
  // upper byte
  assign high_sum = op_a[23:16] + op_b[23:16] + op_c[23:16]
                  + {6'h00, mid_carry};
  assign sum = {high_sum, low_sum[15:0]};

endmodule : ios_adder24

`default_nettype wire

// >>> ios_indexer.sv
// operand b and c selectors, address adder and register indexer
`timescale 1ns/1ns
`default_nettype none

module ios_indexer #(
  parameter int NUM_CTX = ios_pkg::NUM_CTX
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // context state of all contexts
  input wire logic [NUM_CTX-1:0][31:0] next_instruction_holder,
  input wire logic [NUM_CTX-1:0][31:0] stored_word_buffer,
  input wire logic [NUM_CTX-1:0][3:0][31:0] context_register,
  input wire logic [$clog2(NUM_CTX)-1:0] virtual_context,
  // pipeline control
  input wire ios_pkg::ios_main_t main_instruction_holder,
  input wire ios_pkg::ios_ctl_t op_ctl,
  input wire logic [23:0] operand_a,
  input wire logic index_strobe,
  // result to the context instruction holder
  output ios_pkg::ios_out_t context_instruction_holder,
  output logic holder_load,
  // axi4-lite write address and data
  input wire logic [ios_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ios_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // refuse a context count the code field cannot address
  if (NUM_CTX < 2 || NUM_CTX > 16)
  begin : g_bad_ctx
    $error("NUM_CTX must lie between 2 and 16");
  end

  logic [31:0] next_instr_bus;     // active next-instruction holder
  logic [31:0] buffer_word_bus;    // active stored word buffer
  logic [3:0][31:0] ctx_regs;      // active register file
  logic [31:0] src_word;           // instruction being indexed
  logic [3:0] tag;                 // index tag field
  logic [7:0] reg_spec;            // register spec field
  logic [31:0] selected_register_bus; // chosen register
  logic [1:0] c_reg_idx;           // register index for C
  logic [15:0] c_half;             // chosen halfword
  logic c_zero;                    // no indexing
  ios_pkg::ios_bsel_t b_sel;       // operand b source
  logic [31:0] operand_b_selector; // operand b output
  logic [31:0] operand_c_selector; // operand c output
  logic adder_cin;                 // forced increment
  logic [23:0] eff_sum;            // adder result
  logic [7:0] reg_addr;            // developed register address
  logic [31:0] ctrl_reg;           // control register
  logic [31:0] count_reg;          // captured results count
  logic aw_got_reg;                // write address held
  logic w_got_reg;                 // write data held
  logic [7:0] awaddr_reg;          // held write address
  logic [31:0] wdata_reg;          // held write data
  logic [3:0] wstrb_reg;           // held write strobes
  logic wr_fire;                   // write performed this cycle
  logic capture;                   // result captured this cycle

  assign next_instr_bus = next_instruction_holder[virtual_context];
  assign buffer_word_bus = stored_word_buffer[virtual_context];
  assign ctx_regs = context_register[virtual_context];

  assign src_word = main_instruction_holder.nil_swb ? buffer_word_bus
                                                    : next_instr_bus;
  assign tag = src_word[ios_pkg::T_LSB +: ios_pkg::T_W];
  assign reg_spec = src_word[ios_pkg::R_LSB +: ios_pkg::R_W];

  // operand b source priority
  always_comb
  begin
    if (op_ctl.stack_param || op_ctl.indirect_pass)
      b_sel = ios_pkg::IOS_B_SWB_WORD;
    else if (op_ctl.ea_incr || op_ctl.stack_ptr || op_ctl.wce_test)
      b_sel = ios_pkg::IOS_B_MAIN_EA;
    else if (op_ctl.pc_rel_imm)
      b_sel = ios_pkg::IOS_B_EXT;
    else if (main_instruction_holder.nil_swb)
      b_sel = ios_pkg::IOS_B_SWB_N;
    else
      b_sel = ios_pkg::IOS_B_NIR_N;
  end

  // operand b data
  always_comb
  begin
    case (b_sel)
      ios_pkg::IOS_B_NIR_N:
        operand_b_selector = {16'h0000, next_instr_bus[15:0]};
      ios_pkg::IOS_B_SWB_N:
        operand_b_selector = {16'h0000, buffer_word_bus[15:0]};
      ios_pkg::IOS_B_EXT:
        operand_b_selector = {8'h00,
          {ios_pkg::EXT_W{src_word[ios_pkg::SIGN_BIT]}}, src_word[15:0]};
      ios_pkg::IOS_B_SWB_WORD:
        operand_b_selector = buffer_word_bus;
      ios_pkg::IOS_B_MAIN_EA:
        operand_b_selector = {8'h00, main_instruction_holder.ea};
      default:
        operand_b_selector = 32'h0000_0000;
    endcase
  end

  // operand c register choice
  always_comb
  begin
    if (op_ctl.modify_counts)
      c_reg_idx = reg_spec[7:6];
    else
      c_reg_idx = tag[2:1];
  end
  assign selected_register_bus = ctx_regs[c_reg_idx];

  // halfword choice, right half in low bits
  always_comb
  begin
    if (op_ctl.modify_counts)
      c_half = reg_spec[5] ? selected_register_bus[15:0]
                           : selected_register_bus[31:16];
    else
      c_half = tag[0] ? selected_register_bus[15:0]
                      : selected_register_bus[31:16];
  end

  assign c_zero = tag == ios_pkg::T_NOIDX_A || tag == ios_pkg::T_NOIDX_B
               || op_ctl.push_pull || op_ctl.wce_test;

  // operand c data
  always_comb
  begin
    if (op_ctl.modify_counts)
      operand_c_selector = {c_half, ~c_half};
    else if (c_zero)
      operand_c_selector = 32'h0000_0000;
    else
      operand_c_selector = {8'h00, {ios_pkg::EXT_W{c_half[15]}}, c_half};
  end

  // increment for stack pointer, exhaust test, count modify
  assign adder_cin = op_ctl.stack_ptr || op_ctl.wce_test
                  || op_ctl.modify_counts;

  ios_adder24 u_adder (
    .op_a(operand_a),
    .op_b(operand_b_selector[ios_pkg::EA_W-1:0]),
    .op_c(operand_c_selector[ios_pkg::EA_W-1:0]),
    .carry_in(adder_cin),
    .split_carry(op_ctl.modify_counts),
    .sum(eff_sum)
  );

  // register indexer
  always_comb
  begin
    if (op_ctl.reg_is_cr)
      // add base byte of fourth register
      reg_addr = reg_spec + ctx_regs[ios_pkg::BASE_REG]
                 [ios_pkg::BASE_BYTE_LSB +: 8];
    else
      reg_addr = reg_spec;
  end

  assign capture = index_strobe && ctrl_reg[ios_pkg::CTRL_EN_BIT];

  // result capture into the instruction holder
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      context_instruction_holder <= '0;
    else if (capture)
    begin
      context_instruction_holder.eff_addr <= eff_sum;
      context_instruction_holder.reg_addr <= reg_addr;
      context_instruction_holder.size <= op_ctl.size;
    end
  end

  // load pulse beside the captured result
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      holder_load <= 1'b0;
    else
      holder_load <= capture;
  end

  // captured result count
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      count_reg <= 32'h0000_0000;
    else if (wr_fire && awaddr_reg == ios_pkg::COUNT_OFF)
      count_reg <= 32'h0000_0000;
    else if (capture)
      count_reg <= count_reg + 32'h0000_0001;
  end

  // write channel acceptance, address and data in either order
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

  // write address hold
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      aw_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_got_reg <= 1'b0;
  end

  // write data hold
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      w_got_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_got_reg <= 1'b0;
  end

  // control register, low byte lane only
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ctrl_reg <= ios_pkg::CTRL_RESET;
    else if (wr_fire && awaddr_reg == ios_pkg::CTRL_OFF && wstrb_reg[0])
      ctrl_reg <= {31'h0000_0000, wdata_reg[ios_pkg::CTRL_EN_BIT]};
  end

  // write response
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ios_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      // only control and count accept writes, all other addresses answer SLVERR
      s_axi_bresp <= (awaddr_reg == ios_pkg::CTRL_OFF
                   || awaddr_reg == ios_pkg::COUNT_OFF)
                   ? ios_pkg::RESP_OKAY : ios_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  // read data and response
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ios_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ios_pkg::RESP_OKAY;
      case (s_axi_araddr)
        // enable bit
        ios_pkg::CTRL_OFF:
          s_axi_rdata <= ctrl_reg;
        // last effective address
        ios_pkg::LAST_EA_OFF:
          s_axi_rdata <= {8'h00, context_instruction_holder.eff_addr};
        // last register address and size
        ios_pkg::LAST_RA_OFF:
          s_axi_rdata <= {22'h00_0000, context_instruction_holder.size,
                          context_instruction_holder.reg_addr};
        // captured count
        ios_pkg::COUNT_OFF:
          s_axi_rdata <= count_reg;
        // unmapped address
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ios_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : ios_indexer

`default_nettype wire

// >>> ios_indexer_props.sv
// assertions on the indexer operand selector ports
`timescale 1ns/1ns
`default_nettype none

module ios_indexer_props #(
  parameter int NUM_CTX = ios_pkg::NUM_CTX
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // context state and controls
  input wire logic [NUM_CTX-1:0][31:0] next_instruction_holder,
  input wire logic [NUM_CTX-1:0][31:0] stored_word_buffer,
  input wire logic [NUM_CTX-1:0][3:0][31:0] context_register,
  input wire logic [$clog2(NUM_CTX)-1:0] virtual_context,
  input wire ios_pkg::ios_main_t main_instruction_holder,
  input wire ios_pkg::ios_ctl_t op_ctl,
  input wire logic [23:0] operand_a,
  input wire logic index_strobe,
  // result
  input wire ios_pkg::ios_out_t context_instruction_holder,
  input wire logic holder_load
);
  // active word, control bits without kind and size
  logic [31:0] src;
  logic [7:0] ctl;
  logic next_location_flag, t_zero;
  // expected sums and addresses
  logic [23:0] s_disp, s_ext, s_stk, s_ea;
  logic [7:0] r_f, r_cr;
  assign next_location_flag = main_instruction_holder.nil_swb;
  assign src = next_location_flag ? stored_word_buffer[virtual_context] :
    next_instruction_holder[virtual_context];
  assign ctl = op_ctl[10:3];
  assign t_zero = src[27:24] == 4'h0;
  assign s_disp = operand_a + {8'h00, src[15:0]};
  assign s_ext = operand_a + {{8{src[31]}}, src[15:0]};
  assign s_stk = operand_a + stored_word_buffer[virtual_context][23:0];
  assign s_ea = operand_a + main_instruction_holder.ea;
  assign r_f = src[23:16];
  assign r_cr = r_f + context_register[virtual_context][3][7:0];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_load_cause;
    holder_load |-> $past(index_strobe);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("load without capture request");
  property p_nir;
    holder_load && $past(ctl) == 8'h00 && $past(t_zero) && !$past(next_location_flag)
      |-> context_instruction_holder.eff_addr == $past(s_disp);
  endproperty
  a_nir: assert property (p_nir)
    else $error("next holder displacement sum wrong");
  property p_swb;
    holder_load && $past(ctl) == 8'h00 && $past(t_zero) && $past(next_location_flag)
      |-> context_instruction_holder.eff_addr == $past(s_disp);
  endproperty
  a_swb: assert property (p_swb)
    else $error("buffer displacement sum wrong");
  property p_ext;
    holder_load && $past(ctl) == 8'h80 && $past(t_zero)
      |-> context_instruction_holder.eff_addr == $past(s_ext);
  endproperty
  a_ext: assert property (p_ext)
    else $error("sign extended displacement sum wrong");
  property p_stk;
    holder_load && $past(ctl) == 8'h40 && $past(t_zero)
      |-> context_instruction_holder.eff_addr == $past(s_stk);
  endproperty
  a_stk: assert property (p_stk)
    else $error("buffer word sum wrong");
  property p_ea;
    holder_load && $past(ctl) == 8'h10 && $past(t_zero)
      |-> context_instruction_holder.eff_addr == $past(s_ea);
  endproperty
  a_ea: assert property (p_ea)
    else $error("main address sum wrong");
  property p_wce;
    holder_load && $past(ctl) == 8'h04
      |-> context_instruction_holder.eff_addr == $past(s_ea) + 24'h00_0001;
  endproperty
  a_wce: assert property (p_wce)
    else $error("exhaust test sum wrong");
  property p_reg;
    holder_load && !$past(op_ctl.reg_is_cr)
      |-> context_instruction_holder.reg_addr == $past(r_f);
  endproperty
  a_reg: assert property (p_reg)
    else $error("context register address wrong");
  property p_cr;
    holder_load && $past(op_ctl.reg_is_cr)
      |-> context_instruction_holder.reg_addr == $past(r_cr);
  endproperty
  a_cr: assert property (p_cr)
    else $error("communications register address wrong");
  property p_size;
    holder_load |-> context_instruction_holder.size == $past(op_ctl.size);
  endproperty
  a_size: assert property (p_size)
    else $error("operand size wrong");
endmodule : ios_indexer_props

bind ios_indexer ios_indexer_props #(.NUM_CTX(NUM_CTX)) u_props (
  .sys_clk(sys_clk), .reset(reset),
  .next_instruction_holder(next_instruction_holder),
  .stored_word_buffer(stored_word_buffer),
  .context_register(context_register), .virtual_context(virtual_context),
  .main_instruction_holder(main_instruction_holder), .op_ctl(op_ctl),
  .operand_a(operand_a), .index_strobe(index_strobe),
  .context_instruction_holder(context_instruction_holder),
  .holder_load(holder_load)
);
`default_nettype wire

// >>> ios_pipe_model.sv
// far side model of the per-context pipeline registers
`timescale 1ns/1ns
`default_nettype none

module ios_pipe_model #(
  parameter int NUM_CTX = ios_pkg::NUM_CTX
) (
  // active context and its words
  input wire logic [$clog2(NUM_CTX)-1:0] ctx,
  input wire logic [31:0] nir_word,
  input wire logic [31:0] buf_word,
  input wire logic [3:0][31:0] regs,
  // state of every context
  output logic [NUM_CTX-1:0][31:0] nir_all,
  output logic [NUM_CTX-1:0][31:0] buf_all,
  output logic [NUM_CTX-1:0][3:0][31:0] regs_all
);
  // idle contexts carry inverted words so a wrong pick shows
  // buses always driven
  always_comb
  begin
    for (int i = 0; i < NUM_CTX; i++)
    begin
      nir_all[i] = (i == int'(ctx)) ? nir_word : ~nir_word;
      buf_all[i] = (i == int'(ctx)) ? buf_word : ~buf_word;
      regs_all[i] = (i == int'(ctx)) ? regs : ~regs;
    end
  end
endmodule : ios_pipe_model
`default_nettype wire

// >>> indexer_operand_select_tb_top.sv
// self-checking bench for the indexer operand selectors
`timescale 1ns/1ns
`default_nettype none

module indexer_operand_select_tb_top;
  // fixed operand a and main effective address
  localparam logic [23:0] OPA = 24'h12_3456;
  localparam logic [23:0] EA = 24'h00_0FFF;
  // clock, reset and counters
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  int n_fail = 0;
  int check_count = 0;
  int cap_n = 0;
  // last expected capture
  logic [23:0] last_ea;
  logic [7:0] last_ra;
  logic [1:0] last_sz;
  // pipeline side stimulus
  logic [2:0] vc = 3'h0;
  logic [31:0] nir_w = 32'h0000_0000;
  logic [31:0] buf_w = 32'h0000_0000;
  logic [3:0][31:0] regs = {32'h00AB_CDF0, 32'hFFF0_0002,
    32'h7FFF_0010, 32'h1234_8001};
  ios_pkg::ios_main_t mih = '0;
  ios_pkg::ios_ctl_t ctl = '0;
  logic stb = 1'b0;
  // model outputs and results
  logic [7:0][31:0] nir_all, buf_all;
  logic [7:0][3:0][31:0] reg_all;
  ios_pkg::ios_out_t hold;
  logic hl;
  // register bus
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  ios_pipe_model u_model (.ctx(vc), .nir_word(nir_w), .buf_word(buf_w),
    .regs(regs), .nir_all(nir_all), .buf_all(buf_all), .regs_all(reg_all));
  ios_indexer dut (.sys_clk(sys_clk), .reset(reset),
    .next_instruction_holder(nir_all), .stored_word_buffer(buf_all),
    .context_register(reg_all), .virtual_context(vc),
    .main_instruction_holder(mih), .op_ctl(ctl), .operand_a(OPA),
    .index_strobe(stb), .context_instruction_holder(hold),
    .holder_load(hl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one capture on the next context, then judge the holder
  task automatic cap(input logic next_location_flag, input logic [31:0] nw, bw,
    input logic [10:0] c, input logic [23:0] e_ea, input logic [7:0] e_ra);
    @(posedge sys_clk);
    vc <= vc + 3'h1;
    nir_w <= nw;
    buf_w <= bw;
    mih <= {next_location_flag, EA};
    ctl <= ios_pkg::ios_ctl_t'(c);
    stb <= 1'b1;
    @(posedge sys_clk);
    stb <= 1'b0;
    #1;
    cap_n++;
    last_ea = e_ea;
    last_ra = e_ra;
    last_sz = c[1:0];
    chk("load", 32'(hl), 32'h1);
    chk("eff_addr", 32'(hold.eff_addr), 32'(e_ea));
    chk("reg_addr", 32'(hold.reg_addr), 32'(e_ra));
    chk("size", 32'(hold.size), 32'(c[1:0]));
  endtask : cap

  // register write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] er);
    logic ha, hw, b;
    logic [1:0] rs;
    int n;
    b = 1'b0;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 20)
    begin
      @(negedge sys_clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      b = bvalid;
      rs = bresp;
      @(posedge sys_clk);
      awvalid <= awvalid & ~ha;
      wvalid <= wvalid & ~hw;
      n++;
    end
    bready <= 1'b0;
    chk("bvalid", 32'(b), 32'h1);
    chk("bresp", 32'(rs), 32'(er));
  endtask : wr

  // register read
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    logic ha, r;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    r = 1'b0;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r && n < 20)
    begin
      @(negedge sys_clk);
      ha = arvalid & arready;
      r = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge sys_clk);
      arvalid <= arvalid & ~ha;
      n++;
    end
    rready <= 1'b0;
    chk("rvalid", 32'(r), 32'h1);
    chk("rdata", d, ed);
    chk("rresp", 32'(rs), 32'(er));
  endtask : rd

  // displacement from either holder, flag picks the source
  task automatic t_disp;
    for (int n = 0; n < 2; n++)
      cap(n[0], 32'h0012_8421, 32'h0034_7F3C, 11'h000,
        OPA + (n[0] ? 24'h00_7F3C : 24'h00_8421),
        n[0] ? 8'h34 : 8'h12);
  endtask : t_disp

  // b sources and their precedence
  task automatic t_bsrc;
    cap(0, 32'h8056_F00D, 32'h0, 11'h400, OPA + 24'hFF_F00D, 8'h56);
    cap(1, 32'h0, 32'h0056_700D, 11'h400, OPA + 24'h00_700D, 8'h56);
    cap(0, 32'h1111, 32'hA5C3_0F0F, 11'h680, OPA + 24'hC3_0F0F, 0);
    cap(0, 32'h1111, 32'hA5C3_0F0F, 11'h200, OPA + 24'hC3_0F0F, 0);
    cap(0, 32'h1111, 32'hA5C3_0F0F, 11'h100, OPA + 24'hC3_0F0F, 0);
    cap(0, 32'h1111, 32'h0, 11'h480, OPA + EA, 8'h00);
    cap(0, 32'h1111, 32'h0, 11'h080, OPA + EA, 8'h00);
    cap(0, 32'h1111, 32'h0, 11'h040, OPA + EA + 24'h1, 8'h00);
    cap(0, 32'h0300_0000, 32'h0, 11'h020, OPA + EA + 24'h1, 0);
    cap(0, 32'h0300_0005, 32'h0, 11'h010, OPA + 24'h5, 8'h00);
  endtask : t_bsrc

  // every tag value: register, half, sign, no-index codes
  task automatic t_index;
    logic [31:0] r;
    logic [15:0] h;
    logic [23:0] c;
    for (int t = 0; t < 16; t++)
    begin
      r = regs[t[2:1]];
      h = t[0] ? r[15:0] : r[31:16];
      c = (t == 0 || t == 8) ? 24'h0 : {{8{h[15]}}, h};
      cap(0, {4'h0, t[3:0], 24'h0}, 32'h0, 0, OPA + c, 0);
    end
  endtask : t_index

  // modify-stack counts: halfword and complement, split carry
  task automatic t_modify;
    logic [15:0] h, lo;
    logic [7:0] hi;
    // spec bit picks left then right half of register one
    for (int k = 0; k < 2; k++)
    begin
      h = k[0] ? regs[1][15:0] : regs[1][31:16];
      lo = OPA[15:0] + 16'hFFFF + ~h + 16'h0001;
      hi = OPA[23:16] + h[7:0];
      cap(0, {8'h00, 2'b01, k[0], 5'h00, 16'h0000}, 32'h0000_FFFF,
        11'h208, {hi, lo}, {2'b01, k[0], 5'h00});
    end
  endtask : t_modify

  // register addresses with base wrap, every size
  task automatic t_reg;
    for (int s = 0; s < 6; s++)
      cap(0, 32'h0030_0000, 32'h0, {8'h00, s > 2, 2'(s % 3)}, OPA,
        s > 2 ? 8'h20 : 8'h30);
  endtask : t_reg

  // register map, refused capture and count clear
  task automatic t_axi;
    rd(ios_pkg::CTRL_OFF, ios_pkg::CTRL_RESET, ios_pkg::RESP_OKAY);
    rd(ios_pkg::COUNT_OFF, 32'(cap_n), ios_pkg::RESP_OKAY);
    rd(ios_pkg::LAST_EA_OFF, 32'(last_ea), ios_pkg::RESP_OKAY);
    rd(ios_pkg::LAST_RA_OFF, {22'h0, last_sz, last_ra}, ios_pkg::RESP_OKAY);
    wr(ios_pkg::LAST_EA_OFF, 32'h0, 4'hF, ios_pkg::RESP_SLVERR);
    rd(8'h10, 32'h0, ios_pkg::RESP_SLVERR);
    wr(ios_pkg::CTRL_OFF, 32'h0, 4'h0, ios_pkg::RESP_OKAY);
    rd(ios_pkg::CTRL_OFF, 32'h1, ios_pkg::RESP_OKAY);
    wr(ios_pkg::CTRL_OFF, 32'h0, 4'hF, ios_pkg::RESP_OKAY);
    @(posedge sys_clk);
    stb <= 1'b1;
    @(posedge sys_clk);
    stb <= 1'b0;
    #1;
    chk("refused load", 32'(hl), 32'h0);
    wr(ios_pkg::COUNT_OFF, 32'h0, 4'hF, ios_pkg::RESP_OKAY);
    rd(ios_pkg::COUNT_OFF, 32'h0, ios_pkg::RESP_OKAY);
    wr(ios_pkg::CTRL_OFF, 32'h1, 4'hF, ios_pkg::RESP_OKAY);
  endtask : t_axi

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_disp;
    t_bsrc;
    t_index;
    t_modify;
    t_reg;
    t_axi;
    stop_test;
  end

  // watchdog
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    stop_test;
  end
endmodule : indexer_operand_select_tb_top
`default_nettype wire
